// *** mtpp_core.sv ***
// Operation
// - ignore speed change in fixed S-curve or non-symmetric linear auto decel
// - continuous S-curve takes new speed only in constant speed or idle phase
// - read commands return current speed and stored speed setting
// - target is a 4-byte value from both data words
// - relative drive: positive target runs plus, negative runs minus
// - counter-relative drive inverts the direction
// - absolute target is signed destination from logical zero
// - target rewrite in relative drive keeps direction; passed point stops now
// - target write refused during absolute drive
// - line and circle finish points are signed relative offsets
// - bit pattern: plus steps low half, minus steps high half
// - helix: X,Y relative ends; Z,U total or per-turn count
// - manual decel mode starts deceleration at programmed point
// - output pulses are abs target, or abs target minus start position
// - circle centre is signed offset from current position
// - logical position counts output pulses up and down
// - logical position writable and readable anytime
// - encoder position counts encoder pulses, writable and readable anytime
// - plus soft limit writable anytime, controlled by mode register two
// - minus soft limit writable anytime, same controls
// - data is binary two's complement
`timescale 1ns/100ps
module mtpp_core #(
    parameter int AXES = mtpp_pkg::AXES
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_ce,
    input  wire logic                   i_cmd_valid,
    input  wire logic [7:0]             i_cmd_code,
    input  wire logic [AXES-1:0]        i_axis_sel,
    input  wire logic [15:0]            i_data_high,
    input  wire logic [15:0]            i_data_low,
    input  wire logic                   i_rd_valid,
    input  wire logic [7:0]             i_rd_code,
    input  wire logic [1:0]             i_rd_axis,
    input  wire logic [15:0]            i_mode_three,
    input  wire logic [15:0]            i_mode_two,
    input  wire mtpp_pkg::mtpp_kind_t   i_kind,
    input  wire logic                   i_rotation_one,
    input  wire logic [AXES-1:0]        i_driving,
    input  wire mtpp_pkg::mtpp_phase_t  i_phase,
    input  wire logic [AXES-1:0]        i_pulse_plus,
    input  wire logic [AXES-1:0]        i_pulse_minus,
    input  wire logic [AXES-1:0]        i_enc_up,
    input  wire logic [AXES-1:0]        i_enc_down,
    input  wire logic [AXES-1:0][31:0]  i_cur_speed,
    output logic [31:0]                 o_rd_data,
    output logic                        o_rd_valid,
    output logic [AXES-1:0][31:0]       o_pulse_total,
    output logic [AXES-1:0][31:0]       o_rel_end,
    output logic [AXES-1:0][15:0]       o_bits_plus,
    output logic [AXES-1:0][15:0]       o_bits_minus,
    output logic [AXES-1:0]             o_per_turn,
    output logic [AXES-1:0]             o_dir_minus,
    output logic [AXES-1:0]             o_decel_start,
    output logic [AXES-1:0]             o_stop_now,
    output logic [AXES-1:0]             o_plim_hit,
    output logic [AXES-1:0]             o_mlim_hit
);
    import mtpp_pkg::*;

    typedef struct packed {
        logic [AXES-1:0][31:0] lpos;
        logic [AXES-1:0][31:0] epos;
        logic [AXES-1:0][1:0]  enc_s1;
        logic [AXES-1:0][1:0]  enc_s2;
        logic [AXES-1:0]       drv_d;
        logic [AXES-1:0][31:0] total;
        logic [AXES-1:0][31:0] done;
        logic [AXES-1:0][31:0] rel_end;
        logic [AXES-1:0][15:0] bits_p;
        logic [AXES-1:0][15:0] bits_m;
        logic [AXES-1:0]       per_turn;
        logic [AXES-1:0]       dir_m;
        logic [AXES-1:0]       decel;
        logic [AXES-1:0]       stop;
        logic [AXES-1:0]       plim;
        logic [AXES-1:0]       mlim;
        logic [31:0]           rd_data;
        logic                  rd_valid;
    } mtpp_core_t;

    mtpp_core_t st_reg;
    mtpp_core_t st_next;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] mtpp_abs(input logic [31:0] v);
        mtpp_abs = v[31] ? 32'(-v) : v;
    endfunction : mtpp_abs

    logic [31:0] wdata;
    assign wdata = {i_data_high, i_data_low};

    logic        fixed_kind;
    logic        speed_ok;
    logic [AXES-1:0] tp_ok;
    logic [AXES-1:0] sel_we;
    logic [AXES-1:0][31:0] tgt;
    logic [AXES-1:0][31:0] dpt;
    logic [AXES-1:0][31:0] plv;
    logic [AXES-1:0][31:0] mlv;
    logic [AXES-1:0][31:0] spd;

    assign fixed_kind = (i_kind == KIND_REL) || (i_kind == KIND_CREL)
                     || (i_kind == KIND_ABS);

    // ----------------------------------------
    // speed change acceptance
    // ----------------------------------------
    always_comb begin
        speed_ok = 1'b1;
        // fixed auto decel S-curve or asymmetric linear
        if (fixed_kind && !i_mode_three[M3_MANUAL]
                && (i_mode_three[M3_SCURVE] || i_mode_three[M3_ASYM]))
            speed_ok = 1'b0;
        else if (i_kind == KIND_CONT && i_mode_three[M3_SCURVE])
            speed_ok = (i_phase == PH_CONST) || (i_phase == PH_IDLE);
        // symmetric trapezoid relies on host clearing prevention
        else if (fixed_kind)
            speed_ok = 1'b1;
        else if (i_kind != KIND_CONT)
            speed_ok = 1'b0;
    end

    // ----------------------------------------
    // per-axis parameter stores
    // ----------------------------------------
    mtpp_param_if pif[AXES] ();
    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_ax
            // same value, same cycle, every selected axis
            assign sel_we[g] = i_ce && i_cmd_valid && i_axis_sel[g];
            assign tp_ok[g] = !i_driving[g]
                || ((i_kind == KIND_REL || i_kind == KIND_CREL)
                    && (wdata[31] == tgt[g][31]));
            assign pif[g].we       = sel_we[g];
            assign pif[g].code     = i_cmd_code;
            assign pif[g].data     = wdata;
            assign pif[g].speed_ok = !i_driving[g] || speed_ok;
            assign pif[g].tp_ok    = tp_ok[g];
            assign tgt[g] = pif[g].target;
            assign dpt[g] = pif[g].decel_pt;
            assign plv[g] = pif[g].plim;
            assign mlv[g] = pif[g].mlim;
            assign spd[g] = pif[g].speed;
            mtpp_axis_param u_par (
                .i_core_clk (i_core_clk),
                .i_rst      (i_rst),
                .i_ce       (i_ce),
                .p          (pif[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [31:0] cmp;
        logic        start;
        cmp   = RST_WORD;
        start = 1'b0;
        st_next = st_reg;
        st_next.enc_s1 = {i_enc_down, i_enc_up} == '0 ? '0 : st_reg.enc_s1;
        for (int a = 0; a < AXES; a++) begin
            st_next.enc_s1[a] = {i_enc_down[a], i_enc_up[a]};
            st_next.enc_s2[a] = st_reg.enc_s1[a];
            st_next.drv_d[a]  = i_driving[a];
            st_next.decel[a]  = 1'b0;
            st_next.stop[a]   = 1'b0;
            start = i_driving[a] && !st_reg.drv_d[a];
            if (i_pulse_plus[a] && !i_pulse_minus[a])
                st_next.lpos[a] = st_reg.lpos[a] + 32'd1;
            else if (i_pulse_minus[a] && !i_pulse_plus[a])
                st_next.lpos[a] = st_reg.lpos[a] - 32'd1;
            if (sel_we[a] && i_cmd_code == CMD_LPOS)
                st_next.lpos[a] = wdata;
            if (st_reg.enc_s2[a] == 2'b01)
                st_next.epos[a] = st_reg.epos[a] + 32'd1;
            else if (st_reg.enc_s2[a] == 2'b10)
                st_next.epos[a] = st_reg.epos[a] - 32'd1;
            if (sel_we[a] && i_cmd_code == CMD_EPOS)
                st_next.epos[a] = wdata;
            // drive start: latch totals and direction, or the bit patterns for KIND_BITS
            if (start) begin
                st_next.done[a] = RST_WORD;
                case (i_kind)
                    KIND_REL: begin
                        st_next.total[a] = mtpp_abs(tgt[a]);
                        st_next.dir_m[a] = tgt[a][31];
                    end
                    KIND_CREL: begin
                        st_next.total[a] = mtpp_abs(tgt[a]);
                        st_next.dir_m[a] = !tgt[a][31];
                    end
                    KIND_ABS: begin
                        st_next.total[a] = mtpp_abs(32'(tgt[a] - st_reg.lpos[a]));
                        st_next.dir_m[a] = $signed(tgt[a]) < $signed(st_reg.lpos[a]);
                    end
                    KIND_LINE, KIND_CIRC, KIND_HELIX: begin
                        st_next.rel_end[a]  = st_reg.lpos[a] + tgt[a];
                        st_next.total[a]    = mtpp_abs(tgt[a]);
                        st_next.dir_m[a]    = tgt[a][31];
                        st_next.per_turn[a] = (i_kind == KIND_HELIX)
                                              && (a >= 2) && i_rotation_one;
                    end
                    // low half plus, high half minus
                    KIND_BITS: begin
                        st_next.bits_p[a] = tgt[a][15:0];
                        st_next.bits_m[a] = tgt[a][31:16];
                    end
                    default: st_next.total[a] = RST_WORD;
                endcase
            end else if (i_driving[a] && (i_pulse_plus[a] || i_pulse_minus[a])) begin
                st_next.done[a] = st_reg.done[a] + 32'd1;
            end
            if (i_driving[a] && fixed_kind && i_mode_three[M3_MANUAL]
                    && st_reg.done[a] == dpt[a] && st_reg.drv_d[a])
                st_next.decel[a] = 1'b1;
            if (sel_we[a] && i_cmd_code == CMD_TARGET && i_driving[a]
                    && tp_ok[a] && mtpp_abs(wdata) <= st_reg.done[a]) begin
                st_next.stop[a]  = 1'b1;
            end
            if (sel_we[a] && i_cmd_code == CMD_TARGET && i_driving[a] && tp_ok[a])
                st_next.total[a] = mtpp_abs(wdata);
            cmp = i_mode_two[M2_OBJ] ? st_reg.epos[a] : st_reg.lpos[a];
            st_next.plim[a] = i_mode_two[M2_PLIM]
                              && $signed(cmp) >= $signed(plv[a]);
            st_next.mlim[a] = i_mode_two[M2_MLIM]
                              && $signed(cmp) <= $signed(mlv[a]);
        end
        st_next.rd_valid = i_rd_valid;
        if (i_rd_valid) begin
            case (i_rd_code)
                RD_LPOS:   st_next.rd_data = st_reg.lpos[i_rd_axis];
                RD_EPOS:   st_next.rd_data = st_reg.epos[i_rd_axis];
                RD_CURSPD: st_next.rd_data = i_cur_speed[i_rd_axis];
                RD_SPDSET: st_next.rd_data = spd[i_rd_axis];
                default:   st_next.rd_data = RST_WORD;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) st_reg <= '0;
        else if (i_ce) st_reg <= st_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_rd_data     = st_reg.rd_data;
    assign o_rd_valid    = st_reg.rd_valid;
    assign o_pulse_total = st_reg.total;
    assign o_rel_end     = st_reg.rel_end;
    assign o_bits_plus   = st_reg.bits_p;
    assign o_bits_minus  = st_reg.bits_m;
    assign o_per_turn    = st_reg.per_turn;
    assign o_dir_minus   = st_reg.dir_m;
    assign o_decel_start = st_reg.decel;
    assign o_stop_now    = st_reg.stop;
    assign o_plim_hit    = st_reg.plim;
    assign o_mlim_hit    = st_reg.mlim;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    chk_lpos_write: assert property (
        i_ce && sel_we[0] && i_cmd_code == CMD_LPOS |=> st_reg.lpos[0] == $past(wdata))
        else $error("logical position write lost");
    chk_lpos_count: assert property (
        i_ce && !sel_we[0] && i_pulse_plus[0] && !i_pulse_minus[0]
        |=> st_reg.lpos[0] == $past(st_reg.lpos[0]) + 32'd1)
        else $error("logical position did not count up");
    chk_rel_dir: assert property (
        i_ce && i_kind == KIND_REL && i_driving[0] && !st_reg.drv_d[0]
        |=> o_dir_minus[0] == $past(tgt[0][31])) else $error("relative direction wrong");
    chk_crel_dir: assert property (
        i_ce && i_kind == KIND_CREL && i_driving[0] && !st_reg.drv_d[0]
        |=> o_dir_minus[0] != $past(tgt[0][31])) else $error("counter direction wrong");
    chk_scurve_spd: assert property (
        i_ce && i_kind == KIND_CONT && i_mode_three[M3_SCURVE] && i_phase == PH_ACCEL
        |-> !speed_ok) else $error("speed accepted while accelerating");
    chk_fixed_spd: assert property (
        fixed_kind && !i_mode_three[M3_MANUAL] && i_mode_three[M3_ASYM]
        |-> !speed_ok) else $error("speed accepted in auto decel");
    chk_abs_refuse: assert property (
        i_kind == KIND_ABS && i_driving[1] |-> !tp_ok[1])
        else $error("absolute target rewrite allowed");
    chk_read_valid: assert property (
        i_ce && i_rd_valid && i_rd_code == RD_SPDSET
        |=> o_rd_valid && o_rd_data == $past(spd[i_rd_axis]))
        else $error("speed setting read wrong");
    chk_multi_axis: assert property (
        i_ce && i_cmd_valid && i_axis_sel[0] && i_axis_sel[2] && i_cmd_code == CMD_EPOS
        |=> st_reg.epos[0] == st_reg.epos[2]) else $error("axes loaded unequally");
endmodule : mtpp_core

// *** mtpp_pkg.sv ***
// shared constants and types for the motion target parameter block
package mtpp_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int AXES  = 4;
    localparam int DW    = 32;
    // ----------------------------------------
    // write command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_SPEED  = 8'h05;
    localparam logic [7:0] CMD_TARGET = 8'h06;
    localparam logic [7:0] CMD_DECEL  = 8'h07;
    localparam logic [7:0] CMD_CENTRE = 8'h08;
    localparam logic [7:0] CMD_LPOS   = 8'h09;
    localparam logic [7:0] CMD_EPOS   = 8'h0A;
    localparam logic [7:0] CMD_PLIM   = 8'h0B;
    localparam logic [7:0] CMD_MLIM   = 8'h0C;
    // ----------------------------------------
    // read command codes
    // ----------------------------------------
    localparam logic [7:0] RD_LPOS    = 8'h30;
    localparam logic [7:0] RD_EPOS    = 8'h31;
    localparam logic [7:0] RD_CURSPD  = 8'h32;
    localparam logic [7:0] RD_SPDSET  = 8'h45;
    // ----------------------------------------
    // mode register bit positions and reset value
    // ----------------------------------------
    localparam int M3_MANUAL = 0;
    localparam int M3_ASYM   = 1;
    localparam int M3_SCURVE = 2;
    localparam int M3_NOTRI  = 13;
    localparam int M2_PLIM   = 0;
    localparam int M2_MLIM   = 1;
    localparam int M2_OBJ    = 2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // ----------------------------------------
    // drive kinds and speed profile phases
    // ----------------------------------------
    typedef enum logic [2:0] {
        KIND_REL, KIND_CREL, KIND_ABS, KIND_LINE,
        KIND_CIRC, KIND_BITS, KIND_HELIX, KIND_CONT
    } mtpp_kind_t;
    typedef enum logic [1:0] {
        PH_IDLE, PH_ACCEL, PH_CONST, PH_DECEL
    } mtpp_phase_t;
endpackage : mtpp_pkg

// *** mtpp_param_if.sv ***
// per-axis parameter write and stored values
`timescale 1ns/100ps
interface mtpp_param_if;
    logic        we;
    logic [7:0]  code;
    logic [31:0] data;
    logic        speed_ok;
    logic        tp_ok;
    logic [31:0] target;
    logic [31:0] decel_pt;
    logic [31:0] centre;
    logic [31:0] plim;
    logic [31:0] mlim;
    logic [31:0] speed;
    modport ctl (output we, code, data, speed_ok, tp_ok,
                 input target, decel_pt, centre, plim, mlim, speed);
    modport store (input we, code, data, speed_ok, tp_ok,
                   output target, decel_pt, centre, plim, mlim, speed);
endinterface : mtpp_param_if

// *** mtpp_axis_param.sv ***
// one axis worth of written parameters
`timescale 1ns/100ps
module mtpp_axis_param (
    input  wire logic   i_core_clk,
    input  wire logic   i_rst,
    input  wire logic   i_ce,
    mtpp_param_if.store p
);
    import mtpp_pkg::*;

    typedef struct packed {
        logic [31:0] target;
        logic [31:0] decel_pt;
        logic [31:0] centre;
        logic [31:0] plim;
        logic [31:0] mlim;
        logic [31:0] speed;
    } mtpp_par_t;

    mtpp_par_t st_reg;
    mtpp_par_t st_next;

    // ----------------------------------------
    // decode of the write
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        if (p.we) begin
            case (p.code)
                CMD_SPEED: if (p.speed_ok) st_next.speed = p.data;
                CMD_TARGET: if (p.tp_ok) st_next.target = p.data;
                CMD_DECEL: st_next.decel_pt = p.data;
                CMD_CENTRE: st_next.centre = p.data;
                CMD_PLIM: st_next.plim = p.data;
                CMD_MLIM: st_next.mlim = p.data;
                default: st_next = st_reg;
            endcase
        end
    end

    // state register
    always_ff @(posedge i_core_clk) begin
        if (i_rst) st_reg <= '{default: RST_WORD};
        else if (i_ce) st_reg <= st_next;
    end

    assign p.target   = st_reg.target;
    assign p.decel_pt = st_reg.decel_pt;
    assign p.centre   = st_reg.centre;
    assign p.plim     = st_reg.plim;
    assign p.mlim     = st_reg.mlim;
    assign p.speed    = st_reg.speed;

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    chk_tp_refused: assert property (i_ce && p.we && p.code == CMD_TARGET && !p.tp_ok
        |=> $stable(p.target)) else $error("refused target write changed value");
    chk_plim_store: assert property (i_ce && p.we && p.code == CMD_PLIM
        |=> p.plim == $past(p.data)) else $error("plus limit not stored");
    chk_centre_store: assert property (
        i_ce && p.we && p.code == CMD_CENTRE
        |=> p.centre == $past(p.data)) else $error("centre offset not stored");
endmodule : mtpp_axis_param

// *** mtpp_host_model.sv ***
// host model that loads data words and issues write and read commands
`timescale 1ns/100ps
module mtpp_host_model (
    input  wire logic        i_core_clk,
    input  wire logic [31:0] i_rd_data,
    input  wire logic        i_rd_valid,
    output logic             o_cmd_valid,
    output logic [7:0]       o_cmd_code,
    output logic [3:0]       o_axis_sel,
    output logic [15:0]      o_data_high,
    output logic [15:0]      o_data_low,
    output logic             o_rd_req,
    output logic [7:0]       o_rd_code,
    output logic [1:0]       o_rd_axis
);
    // idle command lines from time zero
    initial begin
        {o_cmd_valid, o_rd_req, o_cmd_code, o_rd_code, o_axis_sel, o_rd_axis} = '0;
        {o_data_high, o_data_low} = 32'h0000_0000;
    end
    // high word, low word, then code
    task automatic wr(input logic [7:0] c, input logic [3:0] s, input logic [31:0] d);
        @(negedge i_core_clk);
        {o_data_high, o_data_low} = d;
        o_axis_sel = s;
        o_cmd_code = c;
        o_cmd_valid = 1'h1;
        @(negedge i_core_clk);
        o_cmd_valid = 1'h0;
        {o_data_high, o_data_low} = ~d; // stale words must not be used
    endtask : wr
    // answer is taken one cycle after the request
    task automatic rd(input logic [7:0] c, input logic [1:0] a, output logic [31:0] q);
        @(negedge i_core_clk);
        o_rd_code = c;
        o_rd_axis = a;
        o_rd_req = 1'h1;
        @(negedge i_core_clk);
        o_rd_req = 1'h0;
        q = i_rd_valid ? i_rd_data : ~i_rd_data;
    endtask : rd
endmodule : mtpp_host_model

// *** test_motion_target_position_params.sv ***
// self-checking bench for the per-axis parameter block
`timescale 1ns/100ps
module test_motion_target_position_params;
    import mtpp_pkg::*;
    logic clk, rst, ce, cv, rv, rot, ov;
    logic [7:0] cc, rc;
    logic [3:0] sel, drv, pp, pm, eu, ed, pturn, dm, ds, sn, plh, mlh;
    logic [15:0] dh, dl, m3, m2;
    logic [1:0] ra;
    mtpp_kind_t kind;
    mtpp_phase_t ph;
    logic [3:0][31:0] cs, pt, re;
    logic [3:0][15:0] bp, bm;
    logic [31:0] od, q;
    int err_total = 0, comparisons = 0, stops = 0;
    mtpp_core mtpp_core_i (.i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_cmd_valid(cv),
        .i_cmd_code(cc), .i_axis_sel(sel), .i_data_high(dh), .i_data_low(dl),
        .i_rd_valid(rv), .i_rd_code(rc), .i_rd_axis(ra), .i_mode_three(m3),
        .i_mode_two(m2), .i_kind(kind), .i_rotation_one(rot), .i_driving(drv),
        .i_phase(ph), .i_pulse_plus(pp), .i_pulse_minus(pm), .i_enc_up(eu),
        .i_enc_down(ed), .i_cur_speed(cs), .o_rd_data(od), .o_rd_valid(ov),
        .o_pulse_total(pt), .o_rel_end(re), .o_bits_plus(bp), .o_bits_minus(bm),
        .o_per_turn(pturn), .o_dir_minus(dm), .o_decel_start(ds), .o_stop_now(sn),
        .o_plim_hit(plh), .o_mlim_hit(mlh));
    mtpp_host_model mtpp_host_model_i (.i_core_clk(clk), .i_rd_data(od), .i_rd_valid(ov),
        .o_cmd_valid(cv), .o_cmd_code(cc), .o_axis_sel(sel), .o_data_high(dh),
        .o_data_low(dl), .o_rd_req(rv), .o_rd_code(rc), .o_rd_axis(ra));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic w(input logic [7:0] c, input logic [3:0] s, input logic [31:0] d);
        mtpp_host_model_i.wr(c, s, d);
    endtask : w
    task automatic r(input logic [7:0] c, input logic [1:0] a, input logic [31:0] e);
        mtpp_host_model_i.rd(c, a, q);
        chk(q, e);
    endtask : r
    // a low cycle then the new level, so each axis set in a sees a start
    task automatic start(input logic [3:0] a);
        drv = 4'h0;
        cyc(1);
        drv = a;
        cyc(3);
    endtask : start
    // one-cycle stop pulses are counted as they pass
    always @(posedge clk) stops <= stops + int'(sn[0] === 1'h1);
    task automatic t_counters;
        w(CMD_LPOS, 4'h1, 32'hFFFF_FFF6);
        r(RD_LPOS, 2'h0, 32'hFFFF_FFF6);
        w(CMD_EPOS, 4'h5, 32'h0001_2345);
        r(RD_EPOS, 2'h2, 32'h0001_2345);
        r(RD_EPOS, 2'h1, 32'h0000_0000);
        // one encoder up pulse passes the synchroniser then counts
        eu = 4'h1;
        cyc(1);
        eu = 4'h0;
        cyc(3);
        r(RD_EPOS, 2'h0, 32'h0001_2346);
    endtask : t_counters
    task automatic t_speed;
        w(CMD_SPEED, 4'h1, 32'h0000_0064);
        r(RD_SPDSET, 2'h0, 32'h0000_0064);
        cs[0] = 32'h0000_0309;
        r(RD_CURSPD, 2'h0, 32'h0000_0309);
        kind = KIND_REL;
        ph = PH_CONST;
        drv = 4'h1;
        for (int i = 0; i < 2; i++) begin
            m3 = i ? 16'h0002 : 16'h0004; // S-curve, then asymmetric
            w(CMD_SPEED, 4'h1, 32'h0000_00C8);
            r(RD_SPDSET, 2'h0, 32'h0000_0064);
        end
        kind = KIND_CONT;
        m3 = 16'h0004;
        ph = PH_ACCEL;
        w(CMD_SPEED, 4'h1, 32'h0000_012C);
        r(RD_SPDSET, 2'h0, 32'h0000_0064);
        ph = PH_CONST;
        w(CMD_SPEED, 4'h1, 32'h0000_012C);
        r(RD_SPDSET, 2'h0, 32'h0000_012C);
        kind = KIND_REL;
        m3 = 16'h2000;
        w(CMD_SPEED, 4'h1, 32'h0000_0190);
        r(RD_SPDSET, 2'h0, 32'h0000_0190);
        drv = 4'h0;
    endtask : t_speed
    task automatic t_drive;
        w(CMD_LPOS, 4'h1, 32'h0000_0000);
        w(CMD_TARGET, 4'h1, 32'hFFFF_FFFB);
        start(4'h1);
        chk({31'h0, dm[0]}, 32'h0000_0001);
        chk(pt[0], 32'h0000_0005);
        w(CMD_TARGET, 4'h1, 32'h0000_0009);
        chk(pt[0], 32'h0000_0005);
        repeat (3) begin
            pm = 4'h1;
            cyc(1);
            pm = 4'h0;
            cyc(1);
        end
        r(RD_LPOS, 2'h0, 32'hFFFF_FFFD);
        w(CMD_TARGET, 4'h1, 32'hFFFF_FFFE);
        cyc(2);
        chk(32'(stops), 32'h0000_0001);
        drv = 4'h0;
        kind = KIND_CREL;
        w(CMD_TARGET, 4'h1, 32'h0000_0004);
        start(4'h1);
        chk({31'h0, dm[0]}, 32'h0000_0001);
        drv = 4'h0;
        w(CMD_LPOS, 4'h1, 32'h0000_000A);
        w(CMD_TARGET, 4'h1, 32'h0000_0003);
        kind = KIND_ABS;
        start(4'h1);
        chk(pt[0], 32'h0000_0007);
        chk({31'h0, dm[0]}, 32'h0000_0001);
        w(CMD_TARGET, 4'h1, 32'h0000_0014);
        chk(pt[0], 32'h0000_0007);
        drv = 4'h0;
    endtask : t_drive
    task automatic t_interp;
        w(CMD_LPOS, 4'hF, 32'h0000_0064);
        w(CMD_TARGET, 4'hF, 32'hFFFF_FFF0);
        kind = KIND_LINE;
        start(4'hF);
        chk(re[3], 32'h0000_0054);
        drv = 4'h0;
        w(CMD_TARGET, 4'hF, 32'hABCD_1234);
        kind = KIND_BITS;
        start(4'hF);
        chk({bm[1], bp[1]}, 32'hABCD_1234);
        kind = KIND_HELIX;
        rot = 1'h1;
        start(4'hF);
        chk({28'h0, pturn}, 32'h0000_000C);
        drv = 4'h0;
    endtask : t_interp
    task automatic t_limit;
        m2 = 16'h0003;
        w(CMD_PLIM, 4'h2, 32'h0000_0005);
        w(CMD_MLIM, 4'h2, 32'hFFFF_FFFB);
        w(CMD_LPOS, 4'h2, 32'h0000_0006);
        cyc(2);
        chk({30'h0, plh[1], mlh[1]}, 32'h0000_0002);
        w(CMD_LPOS, 4'h2, 32'hFFFF_FFFA);
        cyc(2);
        chk({30'h0, plh[1], mlh[1]}, 32'h0000_0001);
    endtask : t_limit
    // manual decel point reached after two output pulses
    task automatic t_decel;
        m3 = 16'h0001;
        kind = KIND_REL;
        w(CMD_CENTRE, 4'h1, 32'hFFFF_FF00);
        w(CMD_DECEL, 4'h1, 32'h0000_0002);
        w(CMD_TARGET, 4'h1, 32'h0000_0006);
        start(4'h1);
        repeat (2) begin
            chk({31'h0, ds[0]}, 32'h0000_0000);
            pp = 4'h1;
            cyc(1);
            pp = 4'h0;
            cyc(1);
        end
        chk({31'h0, ds[0]}, 32'h0000_0001);
        drv = 4'h0;
        m3 = 16'h0000;
    endtask : t_decel
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    // clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // reset then scenarios
    initial begin
        {rst, ce} = 2'h3;
        {rot, drv, pp, pm, eu, ed} = 21'h0;
        {m3, m2, cs} = '0;
        kind = KIND_REL;
        ph = PH_IDLE;
        cyc(6);
        rst = 1'h0;
        t_counters;
        t_speed;
        t_drive;
        t_interp;
        t_limit;
        t_decel;
        print_verdict;
    end
    // watchdog
    initial begin
        #20000;
        err_total++;
        print_verdict;
    end
endmodule : test_motion_target_position_params
